// file: src/dgoc_pkg.sv
package dgoc_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_RESET = 4'h1;
  localparam logic [3:0] ADDR_OFFSET = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;

  // Control register fields.
  localparam int CTRL_SLEEP = 0;
  localparam int CTRL_FE_OFF = 1;
  localparam int CTRL_CONV_OFF = 2;
  localparam int CTRL_OUT_DRIVE = 3;
  localparam int CTRL_FLOOR_CLIP = 4;
  localparam int CTRL_BLANK_FORCE = 5;
  localparam int CTRL_PAT_START = 6;
  localparam int CTRL_METHOD_LO = 7;
  localparam int CTRL_METHOD_HI = 8;
  localparam int CTRL_W = 9;
  localparam logic [8:0] CTRL_RESET_VAL = 9'h038;

  // Reset register field.
  localparam int RST_SOFT = 0;

  // Status register fields.
  localparam int STAT_PATTERN = 0;
  localparam int STAT_POWER_DOWN = 1;
  localparam int STAT_BUS_DRIVEN = 2;
  localparam int STAT_FE_ON = 3;
  localparam int STAT_CONV_ON = 4;

  localparam logic [7:0] OFFSET_RESET_VAL = 8'h00;

  // ---------------------------------------------------------------------------
  // Pixel path
  // ---------------------------------------------------------------------------
  localparam int PIX_W = 12;
  localparam int OB_W = 8;

  // Soft reset pulse width.
  localparam int SOFT_RST_NS = 10;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SOFT_RST_CYC_RAW = SOFT_RST_NS / CLK_PERIOD_NS;
  localparam int SOFT_RST_CYC = (SOFT_RST_CYC_RAW < 1) ? 1 : SOFT_RST_CYC_RAW;

endpackage

// file: src/dgoc_sync2.sv
`timescale 1ns/1ps
module dgoc_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Data
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      meta_reg <= '0;
      o_sync <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end

endmodule

// file: src/dgoc_top.sv
`timescale 1ns/1ps
// Summary of operation
// [RULE_01] Progressive counter mode: frame sync loads pattern select with start value.
// [RULE_02] Counter mode: each pre-blank pulse inverts the pattern select, unless a progressive frame sync edge falls in the same cycle.
// [RULE_03] Line-ID method: pre-blank pulse captures line ID level into select.
// [RULE_04] Power-down when pin high or sleep bit set.
// [RULE_05] Power-down turns analog off and floats the 12-bit pixel bus.
// [RULE_06] Power-down by pin or bit resets no register.
// [RULE_07] Register port keeps working during power-down.
// [RULE_08] Frontend-off and converter-off bits disable only their stage.
// [RULE_09] Bus driven only with drive bit high and enable pin low.
// [RULE_10] Output enables touch only the drivers; other logic keeps running.
// [RULE_11] Writing soft reset resets the chip; the bit clears itself.
// [RULE_12] Reset pin low holds the chip in reset; pin pulled up.
// [RULE_13] Power-on reset loads defaults into every register.
// [RULE_14] Floor clip raises codes below the black offset code to it.
// [RULE_15] Calibration data path stays unclipped.
// [RULE_16] Blank force with pre-blank pulse outputs the black offset code.
// [RULE_17] Timing generator drives line ID low on even, high on odd lines.
// [RULE_18] Counter method uses an internal line counter, not an external ID.
// [RULE_19] Offset code zero-extended to 12 bits for clip and clamp.
// [RULE_20] Bus floating takes precedence over clamp and clip selection.
module dgoc_top (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Register port
  input wire logic [dgoc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [dgoc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [dgoc_pkg::DATA_W-1:0] o_rdata,
  // Timing pins
  input wire logic i_pre_blank_pulse,
  input wire logic i_line_id_input,
  input wire logic i_frame_sync,
  input wire logic i_power_down_pin,
  input wire logic i_out_enable_n,
  // Converter data
  input wire logic [dgoc_pkg::PIX_W-1:0] i_conv_data,
  // Pixel output bus
  output logic [dgoc_pkg::PIX_W-1:0] o_pixel_out_bus,
  output logic o_pixel_out_oe,
  // Internal consumers
  output logic [dgoc_pkg::PIX_W-1:0] o_cal_data,
  output logic o_pattern_select,
  output logic o_frontend_on,
  output logic o_converter_on,
  output logic o_analog_on,
  output logic o_chip_rstn
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  localparam int NPIN = 5;
  logic [NPIN-1:0] pins_raw;
  logic [NPIN-1:0] pins_sync;
  logic pre_blank_pulse_s;
  logic lid_s;
  logic fsync_s;
  logic pd_s;
  logic oe_n_s;

  assign pins_raw = {i_out_enable_n, i_power_down_pin, i_frame_sync, i_line_id_input,
                     i_pre_blank_pulse};

  dgoc_sync2 #(
    .W(NPIN)
  ) u_pin_sync (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_async(pins_raw),
    .o_sync(pins_sync)
  );

  assign pre_blank_pulse_s = pins_sync[0];
  assign lid_s = pins_sync[1];
  assign fsync_s = pins_sync[2];
  assign pd_s = pins_sync[3];
  assign oe_n_s = pins_sync[4];

  // ---------------------------------------------------------------------------
  // Chip reset
  // ---------------------------------------------------------------------------
  // The pin reset and power-on reset both arrive on i_rstn; the soft reset bit
  // extends it to all but the pin synchronisers and the read port, and then clears itself.
  logic soft_rst_reg;
  logic [3:0] soft_cnt_reg;
  logic chip_rstn;

  assign chip_rstn = i_rstn && !soft_rst_reg; // RULE_12
  assign o_chip_rstn = chip_rstn;

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      soft_rst_reg <= 1'b0; // RULE_13
      soft_cnt_reg <= 4'h0;
    end else if (soft_rst_reg) begin
      if (soft_cnt_reg == 4'(dgoc_pkg::SOFT_RST_CYC - 1)) begin
        soft_rst_reg <= 1'b0; // RULE_11
        soft_cnt_reg <= 4'h0;
      end else begin
        soft_cnt_reg <= soft_cnt_reg + 4'h1;
      end
    end else if (i_wr && i_addr == dgoc_pkg::ADDR_RESET && i_wdata[dgoc_pkg::RST_SOFT]) begin
      soft_rst_reg <= 1'b1; // RULE_11
      soft_cnt_reg <= 4'h0;
    end
  end

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  // Power-down does not appear here: the registers stay writable and keep their
  // contents whatever the power state.
  logic [dgoc_pkg::CTRL_W-1:0] ctrl_reg;
  logic [dgoc_pkg::OB_W-1:0] offset_reg;

  // Each write strobe updates at most one register; other addresses are ignored.
  always_ff @(posedge i_core_clk) begin
    if (!chip_rstn) begin
      ctrl_reg <= dgoc_pkg::CTRL_RESET_VAL; // RULE_13
      offset_reg <= dgoc_pkg::OFFSET_RESET_VAL;
    end else if (i_wr) begin // RULE_07 RULE_06
      if (i_addr == dgoc_pkg::ADDR_CTRL) begin
        ctrl_reg <= i_wdata[dgoc_pkg::CTRL_W-1:0];
      end
      if (i_addr == dgoc_pkg::ADDR_OFFSET) begin
        offset_reg <= i_wdata[dgoc_pkg::OB_W-1:0];
      end
    end
  end

  logic sleep_bit;
  logic fe_off_bit;
  logic conv_off_bit;
  logic out_drive_bit;
  logic floor_clip_enable;
  logic blank_force_enable;
  logic pattern_start_value;
  logic method_progressive;
  logic method_counter;

  assign sleep_bit = ctrl_reg[dgoc_pkg::CTRL_SLEEP];
  assign fe_off_bit = ctrl_reg[dgoc_pkg::CTRL_FE_OFF];
  assign conv_off_bit = ctrl_reg[dgoc_pkg::CTRL_CONV_OFF];
  assign out_drive_bit = ctrl_reg[dgoc_pkg::CTRL_OUT_DRIVE];
  assign floor_clip_enable = ctrl_reg[dgoc_pkg::CTRL_FLOOR_CLIP];
  assign blank_force_enable = ctrl_reg[dgoc_pkg::CTRL_BLANK_FORCE];
  assign pattern_start_value = ctrl_reg[dgoc_pkg::CTRL_PAT_START];
  assign method_progressive = ctrl_reg[dgoc_pkg::CTRL_METHOD_LO];
  assign method_counter = ctrl_reg[dgoc_pkg::CTRL_METHOD_HI];

  // ---------------------------------------------------------------------------
  // Line pattern select
  // ---------------------------------------------------------------------------
  logic pre_blank_pulse_d_reg;
  logic fsync_d_reg;
  logic pre_blank_pulse_rise;
  logic fsync_rise;
  logic pattern_reg;

  assign pre_blank_pulse_rise = pre_blank_pulse_s && !pre_blank_pulse_d_reg;
  assign fsync_rise = fsync_s && !fsync_d_reg;

  // The edge detectors load the synchronised level in reset, so a pin that is
  // already high when a soft reset ends is not taken for a new edge.
  always_ff @(posedge i_core_clk) begin
    if (!chip_rstn) begin
      pre_blank_pulse_d_reg <= pre_blank_pulse_s;
      fsync_d_reg <= fsync_s;
    end else begin
      pre_blank_pulse_d_reg <= pre_blank_pulse_s;
      fsync_d_reg <= fsync_s;
    end
  end

  // In progressive counter mode, frame sync wins over a pre-blank edge in the
  // same cycle so each frame starts from a known pattern.
  always_ff @(posedge i_core_clk) begin
    if (!chip_rstn) begin
      pattern_reg <= 1'b0;
    end else if (method_counter) begin // RULE_18
      if (fsync_rise && method_progressive) begin
        pattern_reg <= pattern_start_value; // RULE_01
      end else if (pre_blank_pulse_rise) begin
        pattern_reg <= !pattern_reg; // RULE_02
      end
    end else if (pre_blank_pulse_rise) begin
      pattern_reg <= lid_s; // RULE_03 RULE_17
    end
  end

  assign o_pattern_select = pattern_reg;

  // ---------------------------------------------------------------------------
  // Power control
  // ---------------------------------------------------------------------------
  logic power_down;

  // The stage enables are combinational, so a power-down pin change reaches
  // them two cycles after the pin moves, with no further register.
  assign power_down = pd_s || sleep_bit; // RULE_04
  assign o_analog_on = !power_down; // RULE_05
  assign o_frontend_on = !power_down && !fe_off_bit; // RULE_08
  assign o_converter_on = !power_down && !conv_off_bit; // RULE_08

  // ---------------------------------------------------------------------------
  // Output data path
  // ---------------------------------------------------------------------------
  logic [dgoc_pkg::PIX_W-1:0] ob_ext;
  logic [dgoc_pkg::PIX_W-1:0] out_next;
  logic [dgoc_pkg::PIX_W-1:0] out_reg;
  logic [dgoc_pkg::PIX_W-1:0] cal_reg;
  logic oe_next;
  logic oe_reg;

  assign ob_ext = {{(dgoc_pkg::PIX_W - dgoc_pkg::OB_W){1'b0}}, offset_reg}; // RULE_19

  // Blanking is tested first because it replaces the sample outright; the floor
  // clip only ever raises a sample to the same offset code.
  always_comb begin
    if (blank_force_enable && pre_blank_pulse_s) begin
      out_next = ob_ext; // RULE_16
    end else if (floor_clip_enable && i_conv_data < ob_ext) begin
      out_next = ob_ext; // RULE_14
    end else begin
      out_next = i_conv_data;
    end
  end

  assign oe_next = out_drive_bit && !oe_n_s && !power_down; // RULE_09 RULE_05 RULE_20

  // Calibration gets raw data and keeps running while the bus floats.
  always_ff @(posedge i_core_clk) begin
    if (!chip_rstn) begin
      cal_reg <= '0;
    end else begin
      cal_reg <= i_conv_data; // RULE_15 RULE_10
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!chip_rstn) begin
      out_reg <= '0;
      oe_reg <= 1'b0;
    end else begin
      out_reg <= out_next;
      oe_reg <= oe_next; // RULE_10
    end
  end

  assign o_pixel_out_bus = out_reg;
  assign o_pixel_out_oe = oe_reg; // RULE_20
  assign o_cal_data = cal_reg;

  // ---------------------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------------------
  logic [dgoc_pkg::DATA_W-1:0] rdata_next;
  logic [dgoc_pkg::DATA_W-1:0] rdata_reg;

  // Unmapped addresses read as zero, and writes to them change nothing.
  always_comb begin
    rdata_next = '0;
    if (i_rd) begin
      unique case (i_addr)
        dgoc_pkg::ADDR_CTRL: begin
          rdata_next[dgoc_pkg::CTRL_W-1:0] = ctrl_reg;
        end
        dgoc_pkg::ADDR_RESET: begin
          rdata_next[dgoc_pkg::RST_SOFT] = soft_rst_reg;
        end
        dgoc_pkg::ADDR_OFFSET: begin
          rdata_next[dgoc_pkg::OB_W-1:0] = offset_reg;
        end
        dgoc_pkg::ADDR_STATUS: begin
          rdata_next[dgoc_pkg::STAT_PATTERN] = pattern_reg;
          rdata_next[dgoc_pkg::STAT_POWER_DOWN] = power_down;
          rdata_next[dgoc_pkg::STAT_BUS_DRIVEN] = oe_reg;
          rdata_next[dgoc_pkg::STAT_FE_ON] = o_frontend_on;
          rdata_next[dgoc_pkg::STAT_CONV_ON] = o_converter_on;
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end
  end

  // The read port answers on i_rstn only, so status stays readable during a
  // soft reset.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next; // RULE_07
    end
  end

  assign o_rdata = rdata_reg;

endmodule

// file: verif/dgoc_timing_gen.sv
`timescale 1ns/1ps
module dgoc_timing_gen (
  // Clock
  input wire logic i_core_clk,
  // Timing pins
  output logic o_pre_blank_pulse,
  output logic o_line_id_input,
  output logic o_frame_sync
);
  initial begin
    o_pre_blank_pulse = 1'b0;
    o_line_id_input = 1'b0;
    o_frame_sync = 1'b0;
  end
  // Holds the level long enough to pass the device's input synchronisers.
  task automatic set_blank(input logic level);
    @(posedge i_core_clk);
    o_pre_blank_pulse <= level;
    repeat (4) @(posedge i_core_clk);
  endtask
  task automatic line(input logic odd);
    @(posedge i_core_clk);
    o_line_id_input <= odd;
    set_blank(1'b1);
    set_blank(1'b0);
  endtask
  task automatic frame();
    @(posedge i_core_clk);
    o_frame_sync <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    o_frame_sync <= 1'b0;
    repeat (4) @(posedge i_core_clk);
  endtask
endmodule

// file: verif/dgoc_top_assertions.sv
`timescale 1ns/1ps
module dgoc_top_assertions (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Register port
  input wire logic [dgoc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [dgoc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [dgoc_pkg::DATA_W-1:0] o_rdata,
  // Pins and outputs
  input wire logic i_power_down_pin,
  input wire logic i_out_enable_n,
  input wire logic [dgoc_pkg::PIX_W-1:0] i_conv_data,
  input wire logic o_pixel_out_oe,
  input wire logic [dgoc_pkg::PIX_W-1:0] o_cal_data,
  input wire logic o_pattern_select,
  input wire logic o_frontend_on,
  input wire logic o_converter_on,
  input wire logic o_analog_on,
  input wire logic o_chip_rstn
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  a_reset_values: assert property (
    $rose(i_rstn) |-> o_rdata == '0 && !o_pixel_out_oe && !o_pattern_select && !$past(o_chip_rstn))
    else $error("outputs not at reset values");
  a_rdata_one_cycle: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("read data outside its cycle");
  a_soft_self_clear: assert property (
    i_wr && i_addr == dgoc_pkg::ADDR_RESET && i_wdata[0] |=> !o_chip_rstn ##1 o_chip_rstn)
    else $error("soft reset pulse wrong");
  a_cal_unclipped: assert property (
    o_chip_rstn && $past(o_chip_rstn) |-> o_cal_data == $past(i_conv_data))
    else $error("calibration data altered");
  a_pd_pin_floats: assert property (
    i_power_down_pin [*4] |-> !o_pixel_out_oe && !o_analog_on)
    else $error("bus or analog active in power down");
  a_oe_pin_floats: assert property (i_out_enable_n [*4] |-> !o_pixel_out_oe)
    else $error("bus driven with enable pin high");
  a_oe_needs_power: assert property (o_pixel_out_oe |-> $past(o_analog_on))
    else $error("bus driven while powered down");
  a_stage_gating: assert property (!o_analog_on |-> !o_frontend_on && !o_converter_on)
    else $error("stage on while analog off");
endmodule

bind dgoc_top dgoc_top_assertions dgoc_top_assertions_inst (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_power_down_pin(i_power_down_pin),
  .i_out_enable_n(i_out_enable_n), .i_conv_data(i_conv_data), .o_pixel_out_oe(o_pixel_out_oe),
  .o_cal_data(o_cal_data), .o_pattern_select(o_pattern_select), .o_frontend_on(o_frontend_on),
  .o_converter_on(o_converter_on), .o_analog_on(o_analog_on), .o_chip_rstn(o_chip_rstn)
);

// file: verif/tb_dgoc_top.sv
`timescale 1ns/1ps
module tb_dgoc_top;
  logic i_core_clk, i_rstn, i_wr, i_rd, i_power_down_pin, i_out_enable_n;
  logic [dgoc_pkg::ADDR_W-1:0] i_addr;
  logic [dgoc_pkg::DATA_W-1:0] i_wdata, o_rdata;
  logic [dgoc_pkg::PIX_W-1:0] i_conv_data, o_pixel_out_bus, o_cal_data;
  logic pre_blank_pulse, line_id, fsync, oe, pat, fe_on, conv_on, an_on, chip_rstn;
  int errors;
  int n_compared;
  dgoc_top dgoc_top_inst (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pre_blank_pulse(pre_blank_pulse),
    .i_line_id_input(line_id), .i_frame_sync(fsync), .i_power_down_pin(i_power_down_pin),
    .i_out_enable_n(i_out_enable_n), .i_conv_data(i_conv_data), .o_pixel_out_bus(o_pixel_out_bus),
    .o_pixel_out_oe(oe), .o_cal_data(o_cal_data), .o_pattern_select(pat), .o_frontend_on(fe_on),
    .o_converter_on(conv_on), .o_analog_on(an_on), .o_chip_rstn(chip_rstn));
  dgoc_timing_gen dgoc_timing_gen_inst (.i_core_clk(i_core_clk), .o_pre_blank_pulse(pre_blank_pulse),
    .o_line_id_input(line_id), .o_frame_sync(fsync));
  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input string name, input logic [3:0] a, input logic [15:0] exp);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    chk(name, exp, o_rdata);
  endtask
  // Moves the power-down and output enable pins together, right after an edge.
  task automatic drive_pins(input logic pd, input logic oen);
    @(posedge i_core_clk);
    i_power_down_pin <= pd;
    i_out_enable_n <= oen;
  endtask
  // Applies one sample; calibration data must follow it whatever the bus does.
  task automatic pix(input logic [11:0] c, input logic [11:0] eb, input logic eo);
    @(posedge i_core_clk);
    i_conv_data <= c;
    repeat (3) @(posedge i_core_clk);
    #1;
    chk("oe", 16'(eo), 16'(oe));
    if (eo) chk("bus", 16'(eb), 16'(o_pixel_out_bus));
    chk("cal", 16'(c), 16'(o_cal_data));
  endtask
  task automatic finish_test();
    if (errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge i_core_clk);
    errors++;
    finish_test();
  end
  initial begin
    {i_rstn, i_wr, i_rd, i_power_down_pin, i_out_enable_n} = 5'h00;
    i_addr = '0;
    i_wdata = '0;
    i_conv_data = '0;
    repeat (12) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    rd_chk("ctrl", dgoc_pkg::ADDR_CTRL, 16'h0038);
    rd_chk("offset", dgoc_pkg::ADDR_OFFSET, 16'h0000);
    wr(dgoc_pkg::ADDR_OFFSET, 16'h0040);
    pix(12'h03F, 12'h040, 1'b1);
    pix(12'h040, 12'h040, 1'b1);
    pix(12'h123, 12'h123, 1'b1);
    for (int v = 12'h03E; v <= 12'h041; v++) begin
      pix(12'(v), (v < 12'h040) ? 12'h040 : 12'(v), 1'b1);
    end
    dgoc_timing_gen_inst.set_blank(1'b1);
    pix(12'h123, 12'h040, 1'b1);
    wr(dgoc_pkg::ADDR_CTRL, 16'h0018);
    pix(12'h123, 12'h123, 1'b1);
    dgoc_timing_gen_inst.set_blank(1'b0);
    wr(dgoc_pkg::ADDR_CTRL, 16'h0028);
    pix(12'h010, 12'h010, 1'b1);
    wr(dgoc_pkg::ADDR_CTRL, 16'h0038);
    wr(dgoc_pkg::ADDR_OFFSET, 16'h00FF);
    pix(12'h100, 12'h100, 1'b1);
    dgoc_timing_gen_inst.line(1'b1);
    dgoc_timing_gen_inst.line(1'b1);
    chk("pattern", 16'h0001, 16'(pat));
    dgoc_timing_gen_inst.line(1'b0);
    chk("pattern", 16'h0000, 16'(pat));
    wr(dgoc_pkg::ADDR_CTRL, 16'h00B8);
    dgoc_timing_gen_inst.line(1'b1);
    chk("pattern", 16'h0001, 16'(pat));
    wr(dgoc_pkg::ADDR_CTRL, 16'h0178);
    dgoc_timing_gen_inst.line(1'b1);
    chk("pattern", 16'h0000, 16'(pat));
    dgoc_timing_gen_inst.frame();
    chk("pattern", 16'h0000, 16'(pat));
    wr(dgoc_pkg::ADDR_CTRL, 16'h01F8);
    dgoc_timing_gen_inst.frame();
    chk("pattern", 16'h0001, 16'(pat));
    dgoc_timing_gen_inst.line(1'b0);
    chk("pattern", 16'h0000, 16'(pat));
    dgoc_timing_gen_inst.line(1'b0);
    chk("pattern", 16'h0001, 16'(pat));
    wr(dgoc_pkg::ADDR_CTRL, 16'h0038);
    rd_chk("status", dgoc_pkg::ADDR_STATUS, 16'h001D);
    drive_pins(1'b0, 1'b1);
    pix(12'h0AA, 12'h000, 1'b0);
    chk("analog", 16'h0001, 16'(an_on));
    drive_pins(1'b0, 1'b0);
    wr(dgoc_pkg::ADDR_CTRL, 16'h0030);
    pix(12'h0AA, 12'h000, 1'b0);
    wr(dgoc_pkg::ADDR_CTRL, 16'h0038);
    drive_pins(1'b1, 1'b0);
    pix(12'h0AB, 12'h000, 1'b0);
    chk("analog", 16'h0000, 16'(an_on));
    rd_chk("offset", dgoc_pkg::ADDR_OFFSET, 16'h00FF);
    wr(dgoc_pkg::ADDR_OFFSET, 16'h0055);
    drive_pins(1'b0, 1'b0);
    pix(12'h010, 12'h055, 1'b1);
    wr(dgoc_pkg::ADDR_CTRL, 16'h0039);
    pix(12'h0AB, 12'h000, 1'b0);
    chk("analog", 16'h0000, 16'(an_on));
    wr(dgoc_pkg::ADDR_CTRL, 16'h003A);
    chk("stages", 16'h0011, {7'h00, fe_on, 3'h0, conv_on, 3'h0, an_on});
    wr(dgoc_pkg::ADDR_CTRL, 16'h003C);
    chk("stages", 16'h0101, {7'h00, fe_on, 3'h0, conv_on, 3'h0, an_on});
    wr(4'hF, 16'hFFFF);
    rd_chk("unmapped", 4'hF, 16'h0000);
    wr(dgoc_pkg::ADDR_RESET, 16'h0001);
    rd_chk("soft", dgoc_pkg::ADDR_RESET, 16'h0000);
    rd_chk("ctrl", dgoc_pkg::ADDR_CTRL, 16'h0038);
    rd_chk("offset", dgoc_pkg::ADDR_OFFSET, 16'h0000);
    wr(dgoc_pkg::ADDR_OFFSET, 16'h0077);
    @(posedge i_core_clk);
    i_rstn <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    rd_chk("offset", dgoc_pkg::ADDR_OFFSET, 16'h0000);
    finish_test();
  end
endmodule
